// >>> src/array_engine.sv
// One array's operation engine: busy timer and erased-state flag
`timescale 1ns/1ps
`default_nettype none
module array_engine
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Operation request
  input  wire logic        start,
  input  wire op_kind_type kind,
  // State
  output logic             busy,
  output logic             erased
);

  logic [7:0]  count;
  logic [7:0]  next_count;
  logic        next_busy;
  logic        next_erased;

  always_comb begin
    next_count  = count;
    next_busy   = busy;
    next_erased = erased;
    if (start) begin
      next_busy  = 1'b1;
      next_count = OP_CYCLES;
      if (kind == OP_PROG) begin
        next_erased = 1'b0;
      end else if (kind == OP_MASS || kind == OP_SECT) begin
        next_erased = 1'b1;
      end
    end else if (busy) begin
      next_count = count - 8'h01;
      if (count == 8'h01) begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count  <= 8'h00;
      busy   <= 1'b0;
      erased <= 1'b0;
    end else begin
      count  <= next_count;
      busy   <= next_busy;
      erased <= next_erased;
    end
  end

endmodule : array_engine
`default_nettype wire

// >>> src/flash_cmd_pkg.sv
// Package of constants for the flash and EEPROM command sequencer
package flash_cmd_pkg;

  // ****************************************************
  // Register map (word indices on the plain port)
  // ****************************************************
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_CMD     = 4'h1;
  localparam logic [3:0] REG_PARAM   = 4'h2;
  localparam logic [3:0] REG_PROT    = 4'h3;
  localparam logic [3:0] REG_KEY     = 4'h4;
  localparam logic [3:0] REG_MARGIN  = 4'h5;
  localparam logic [3:0] REG_STATE   = 4'h6;

  // Status bit positions
  localparam int ST_COMPLETE = 7;
  localparam int ST_ERROR    = 5;
  localparam int ST_BLANK  = 1;

  // Protection bit positions
  localparam int PR_PLDIS = 0;
  localparam int PR_PHDIS = 1;
  localparam int PR_POPEN = 2;
  localparam int PR_EOPEN = 3;

  // Parameter word: array select bit
  localparam int PA_TARGET_EE = 15;

  // ****************************************************
  // Command codes
  // ****************************************************
  localparam logic [7:0] CMD_EV_ALL     = 8'h01;
  localparam logic [7:0] CMD_EV_BLOCK   = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLK  = 8'h09;
  localparam logic [7:0] CMD_UNSECURE   = 8'h0b;
  localparam logic [7:0] CMD_BACKDOOR   = 8'h0c;
  localparam logic [7:0] CMD_USER_MARG  = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARG = 8'h0e;
  localparam logic [7:0] CMD_EV_EE_SECT = 8'h10;
  localparam logic [7:0] CMD_PROG_EE    = 8'h11;
  localparam logic [7:0] CMD_ERASE_EE   = 8'h12;
  localparam logic [7:0] CMD_PROT_OVR   = 8'h13;

  // Margin level zero means normal
  localparam logic [1:0] MARGIN_NORMAL = 2'h0;
  localparam logic [2:0] EE_WORDS_MIN  = 3'h1;
  localparam logic [2:0] EE_WORDS_MAX  = 3'h4;

  // Array operation kinds
  typedef enum logic [2:0] {
    OP_IDLE   = 3'h0,
    OP_READ   = 3'h1,
    OP_MARGIN = 3'h2,
    OP_PROG   = 3'h3,
    OP_SECT   = 3'h4,
    OP_MASS   = 3'h5,
    OP_VERIFY = 3'h6
  } op_kind_type;

  // Array engine timing
  localparam int OP_TIME_US = 10;
  localparam int CLK_MHZ    = 10;
  localparam logic [7:0] OP_CYCLES = 8'(OP_TIME_US * CLK_MHZ);

endpackage : flash_cmd_pkg

// >>> src/flash_eeprom_command_set.sv
// Command decoder and overlap arbiter for program flash and EEPROM
// Summary of operation
// - Unsecure erases both arrays, verifies, releases
// - Backdoor key match releases security
// - User margin level for flash or EEPROM
// - Field margin only in special mode
// - Protection override after key verified
// - Erase verify all, or flash or EEPROM block
// - Erase all needs all open bits
// - EEPROM block erase needs EEPROM open
// - Verify EEPROM section words erased
// - Program one to four EEPROM words
// - Erase addressed EEPROM sector
// - Flash reads allowed during EEPROM program or sector erase
// - No other flash/EEPROM overlap allowed
// - Non-normal flash margin makes flash reads margin reads
// - Writing one to complete flag launches
// - Invalid code sets access error
`timescale 1ns/1ps
`default_nettype none
module flash_eeprom_command_set
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // Mode and security pins
  input  wire logic        special_mode_pin,
  input  wire logic        secure_pin,
  input  wire logic [15:0] stored_key,
  // Flash read requests from the CPU side
  input  wire logic        pflash_read_req,
  output logic             pflash_read_grant,
  output logic             pflash_read_margin,
  // State outputs
  output logic             secured,
  output logic             protection_override
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [1:0] mode_sync;
  logic [1:0] sec_sync;
  logic [1:0] sec_fill;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_sync <= 2'h0;
      sec_sync  <= 2'h0;
      sec_fill  <= 2'h0;
    end else begin
      mode_sync <= {mode_sync[0], special_mode_pin};
      sec_sync  <= {sec_sync[0], secure_pin};
      sec_fill  <= {sec_fill[0], 1'b1};
    end
  end
  logic special_mode;
  assign special_mode = mode_sync[1];

  // ****************************************************
  // Registers and state
  // ****************************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_RUN    = 2'b11,
    ST_VERIFY = 2'b10
  } seq_type;

  seq_type     state;
  seq_type     next_state;
  logic        command_complete_flag;
  logic        next_complete;
  logic        access_error_flag;
  logic        next_error;
  logic        blank_fail;
  logic        next_blank_fail;
  logic [7:0]  command_code_field;
  logic [7:0]  next_cmd;
  logic [15:0] param;
  logic [15:0] next_param;
  logic [3:0]  prot;
  logic [3:0]  next_prot;
  logic [15:0] key;
  logic [15:0] next_key;
  logic [1:0]  pflash_margin;
  logic [1:0]  next_pflash_margin;
  logic [1:0]  eeprom_margin;
  logic [1:0]  next_eeprom_margin;
  logic        next_secured;
  logic        sec_seen;
  logic        next_sec_seen;
  logic        next_override;
  logic        pf_start;
  logic        ee_start;
  op_kind_type pf_kind;
  op_kind_type ee_kind;
  op_kind_type ee_cur;
  op_kind_type next_ee_cur;
  logic        pf_busy;
  logic        ee_busy;
  logic        pf_erased;
  logic        ee_erased;
  logic [15:0] next_rdata;
  logic        next_grant;
  logic        next_rmargin;

  // Parameter word: bit 15 selects EEPROM, low bits give count
  logic        target_ee;
  logic [2:0]  word_count;
  logic [1:0]  level;
  assign target_ee  = param[PA_TARGET_EE];
  assign word_count = param[2:0];
  assign level      = param[1:0];

  logic all_open;
  assign all_open = prot[PR_PLDIS] & prot[PR_PHDIS] & prot[PR_POPEN]
                    & prot[PR_EOPEN];

  // ****************************************************
  // Array engines
  // ****************************************************
  array_engine pf_engine (
    .clk    (clk),
    .resetn (resetn),
    .start  (pf_start),
    .kind   (pf_kind),
    .busy   (pf_busy),
    .erased (pf_erased)
  );

  array_engine ee_engine (
    .clk    (clk),
    .resetn (resetn),
    .start  (ee_start),
    .kind   (ee_kind),
    .busy   (ee_busy),
    .erased (ee_erased)
  );

  // ****************************************************
  // Command sequencer
  // ****************************************************
  always_comb begin
    next_state         = state;
    next_complete      = command_complete_flag;
    next_error         = access_error_flag;
    next_blank_fail    = blank_fail;
    next_cmd           = command_code_field;
    next_param         = param;
    next_prot          = prot;
    next_key           = key;
    next_pflash_margin = pflash_margin;
    next_eeprom_margin = eeprom_margin;
    next_secured       = secured;
    next_sec_seen      = sec_seen;
    next_override      = protection_override;
    next_ee_cur        = ee_cur;
    pf_start           = 1'b0;
    ee_start           = 1'b0;
    pf_kind            = OP_IDLE;
    ee_kind            = OP_IDLE;
    // Strap taken once, after both sync stages hold the pin
    if (!sec_seen && sec_fill[1]) begin
      next_secured  = sec_sync[1];
      next_sec_seen = 1'b1;
    end
    // Loads ignored while a command runs
    if (wr && command_complete_flag) begin
      unique case (addr)
        REG_CMD:   next_cmd   = wdata[7:0];
        REG_PARAM: next_param = wdata;
        REG_PROT:  next_prot  = wdata[3:0];
        REG_KEY:   next_key   = wdata;
        default:   ;
      endcase
    end
    // Error flag cleared by writing one
    if (wr && addr == REG_STATUS && wdata[ST_ERROR]) begin
      next_error = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        // launch by writing one to flag
        if (wr && addr == REG_STATUS && wdata[ST_COMPLETE]
            && command_complete_flag && !access_error_flag) begin
          next_complete   = 1'b0;
          next_blank_fail = 1'b0;
          next_state      = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state    = ST_IDLE;
        next_complete = 1'b1;
        if (pf_busy || ee_busy) begin
          next_state    = ST_WAIT;
          next_complete = 1'b0;
        end else begin
          unique case (command_code_field)
            CMD_EV_ALL: begin
              next_blank_fail = !(pf_erased && ee_erased);
            end
            CMD_EV_BLOCK: begin
              next_blank_fail = target_ee ? !ee_erased : !pf_erased;
            end
            CMD_EV_EE_SECT: begin
              next_blank_fail = !ee_erased;
            end
            // mass erase gated by open bits
            CMD_ERASE_ALL: begin
              if (all_open) begin
                pf_start      = 1'b1;
                ee_start      = 1'b1;
                pf_kind       = OP_MASS;
                ee_kind       = OP_MASS;
                next_ee_cur   = OP_MASS;
                next_state    = ST_RUN;
                next_complete = 1'b0;
              end else begin
                next_error = 1'b1;
              end
            end
            CMD_ERASE_BLK: begin
              if (target_ee && prot[PR_EOPEN]) begin
                ee_start      = 1'b1;
                ee_kind       = OP_MASS;
                next_ee_cur   = OP_MASS;
                next_state    = ST_RUN;
                next_complete = 1'b0;
              end else if (!target_ee && prot[PR_PLDIS]
                           && prot[PR_PHDIS] && prot[PR_POPEN]) begin
                pf_start      = 1'b1;
                pf_kind       = OP_MASS;
                next_state    = ST_RUN;
                next_complete = 1'b0;
              end else begin
                next_error = 1'b1;
              end
            end
            CMD_UNSECURE: begin
              pf_start      = 1'b1;
              ee_start      = 1'b1;
              pf_kind       = OP_MASS;
              ee_kind       = OP_MASS;
              next_ee_cur   = OP_MASS;
              next_state    = ST_VERIFY;
              next_complete = 1'b0;
            end
            CMD_BACKDOOR: begin
              if (key == stored_key) begin
                next_secured = 1'b0;
              end else begin
                next_error = 1'b1;
              end
            end
            CMD_USER_MARG: begin
              if (target_ee) begin
                next_eeprom_margin = level;
              end else begin
                next_pflash_margin = level;
              end
            end
            CMD_FIELD_MARG: begin
              if (!special_mode) begin
                next_error = 1'b1;
              end else if (target_ee) begin
                next_eeprom_margin = level;
              end else begin
                next_pflash_margin = level;
              end
            end
            CMD_PROG_EE: begin
              if (word_count >= EE_WORDS_MIN
                  && word_count <= EE_WORDS_MAX) begin
                ee_start      = 1'b1;
                ee_kind       = OP_PROG;
                next_ee_cur   = OP_PROG;
                next_state    = ST_RUN;
                next_complete = 1'b0;
              end else begin
                next_error = 1'b1;
              end
            end
            CMD_ERASE_EE: begin
              ee_start      = 1'b1;
              ee_kind       = OP_SECT;
              next_ee_cur   = OP_SECT;
              next_state    = ST_RUN;
              next_complete = 1'b0;
            end
            CMD_PROT_OVR: begin
              if (key == stored_key) begin
                next_override = 1'b1;
              end else begin
                next_error = 1'b1;
              end
            end
            default: begin
              next_error = 1'b1;
            end
          endcase
        end
      end
      ST_RUN: begin
        if (!pf_busy && !ee_busy) begin
          next_state    = ST_IDLE;
          next_complete = 1'b1;
          next_ee_cur   = OP_IDLE;
        end
      end
      ST_VERIFY: begin
        if (!pf_busy && !ee_busy) begin
          next_state    = ST_IDLE;
          next_complete = 1'b1;
          next_ee_cur = OP_IDLE;
          // release only if both read erased
          if (pf_erased && ee_erased) begin
            next_secured = 1'b0;
          end else begin
            next_blank_fail = 1'b1;
          end
        end
      end
    endcase
  end

  // ****************************************************
  // Flash read arbitration and read port
  // ****************************************************
  always_comb begin
    // non-normal level makes it a margin read
    next_rmargin = pflash_margin != MARGIN_NORMAL;
    // reads pass during EEPROM program and sector erase
    next_grant = pflash_read_req && !pf_busy && !next_rmargin
                 && (!ee_busy || ee_cur == OP_PROG || ee_cur == OP_SECT);
    next_rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        REG_STATUS: begin
          next_rdata[ST_COMPLETE] = command_complete_flag;
          next_rdata[ST_ERROR]    = access_error_flag;
          next_rdata[ST_BLANK]  = blank_fail;
        end
        REG_CMD:    next_rdata = {8'h00, command_code_field};
        REG_PARAM:  next_rdata = param;
        REG_PROT:   next_rdata = {12'h000, prot};
        REG_MARGIN: next_rdata = {12'h000, eeprom_margin, pflash_margin};
        REG_STATE:  next_rdata = {12'h000, pf_busy, ee_busy,
                                  protection_override, secured};
        default:    next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state                 <= ST_IDLE;
      command_complete_flag <= 1'b1;
      access_error_flag     <= 1'b0;
      blank_fail            <= 1'b0;
      command_code_field    <= 8'h00;
      param                 <= 16'h0000;
      prot                  <= 4'h0;
      key                   <= 16'h0000;
      pflash_margin         <= MARGIN_NORMAL;
      eeprom_margin         <= MARGIN_NORMAL;
      secured               <= 1'b1;
      sec_seen              <= 1'b0;
      protection_override   <= 1'b0;
      ee_cur                <= OP_IDLE;
      rdata                 <= 16'h0000;
      pflash_read_grant     <= 1'b0;
      pflash_read_margin    <= 1'b0;
    end else begin
      state                 <= next_state;
      command_complete_flag <= next_complete;
      access_error_flag     <= next_error;
      blank_fail            <= next_blank_fail;
      command_code_field    <= next_cmd;
      param                 <= next_param;
      prot                  <= next_prot;
      key                   <= next_key;
      pflash_margin         <= next_pflash_margin;
      eeprom_margin         <= next_eeprom_margin;
      secured               <= next_secured;
      sec_seen              <= next_sec_seen;
      protection_override   <= next_override;
      ee_cur                <= next_ee_cur;
      rdata                 <= next_rdata;
      pflash_read_grant     <= next_grant;
      pflash_read_margin    <= next_rmargin;
    end
  end

endmodule : flash_eeprom_command_set
`default_nettype wire

// >>> testbench/flash_cmd_props.sv
// Port-level assertions for the flash and EEPROM command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_props
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Pins and state
  input wire logic        special_mode_pin,
  input wire logic        secure_pin,
  input wire logic [15:0] stored_key,
  input wire logic        pflash_read_req,
  input wire logic        pflash_read_grant,
  input wire logic        pflash_read_margin,
  input wire logic        secured,
  input wire logic        protection_override
);
  // ****************************************************
  // Cycles since the last launch write
  // ****************************************************
  logic       launch;
  logic [9:0] since_launch;
  logic [9:0] next_since_launch;

  assign launch = wr && addr == REG_STATUS && wdata[ST_COMPLETE];

  // Saturates so a long idle never wraps into a false recent launch
  always_comb begin
    next_since_launch = since_launch;
    if (!resetn) begin
      next_since_launch = 10'h3ff;
    end else if (launch) begin
      next_since_launch = 10'h0;
    end else if (since_launch != 10'h3ff) begin
      next_since_launch = since_launch + 10'h1;
    end
  end

  always_ff @(posedge clk) begin
    since_launch <= next_since_launch;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("read data not zero outside a read answer");
  rdata_unmapped_a: assert property (
    $past(rd) && $past(addr) > REG_STATE |-> rdata == 16'h0)
    else $error("unmapped read returned data");
  grant_cause_a: assert property (
    pflash_read_grant |-> $past(pflash_read_req))
    else $error("flash read granted without request");
  margin_blocks_a: assert property (
    pflash_read_margin && $past(pflash_read_margin) |-> !pflash_read_grant)
    else $error("margin read granted as normal read");
  grant_idle_a: assert property (
    pflash_read_req && $past(pflash_read_req) && !pflash_read_margin
    && since_launch == 10'h3ff |-> pflash_read_grant)
    else $error("idle flash read not granted");
  override_cause_a: assert property (
    $rose(protection_override) |-> since_launch <= 10'd8)
    else $error("override set without a command");
  unsecure_cause_a: assert property (
    $fell(secured) && secure_pin |-> since_launch <= 10'd400)
    else $error("security released without a command");
  secured_reset_a: assert property ($rose(resetn) |-> secured [*2])
    else $error("secured state not held after reset");

  cover property (launch);
  cover property (pflash_read_grant);
  cover property ($fell(secured));
endmodule : flash_cmd_props

bind flash_eeprom_command_set flash_cmd_props u_props (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .special_mode_pin(special_mode_pin),
  .secure_pin(secure_pin), .stored_key(stored_key),
  .pflash_read_req(pflash_read_req),
  .pflash_read_grant(pflash_read_grant),
  .pflash_read_margin(pflash_read_margin), .secured(secured),
  .protection_override(protection_override));
`default_nettype wire

// >>> testbench/tb_flash_eeprom_command_set.sv
// Self-checking bench for the flash and EEPROM command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_eeprom_command_set
  import flash_cmd_pkg::*;
;
  localparam logic [15:0] KEY = 16'h5a3c;
  localparam logic [15:0] MA  = 16'h00a2;
  localparam logic [15:0] ME  = 16'h00a0;
  localparam logic [15:0] OK  = 16'h0080;
  localparam logic [15:0] ERR = 16'h00a0;
  localparam logic [15:0] BL  = 16'h0082;

  logic        clk;
  logic        resetn;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        special_mode_pin;
  logic        secure_pin;
  logic [15:0] stored_key;
  logic        pflash_read_req;
  logic        pflash_read_grant;
  logic        pflash_read_margin;
  logic        secured;
  logic        protection_override;
  logic [15:0] v;
  logic [7:0]  bad [3] = '{8'h00, 8'h14, 8'hff};
  int          n_errors = 0;
  int          n_checks = 0;

  flash_eeprom_command_set dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .special_mode_pin(special_mode_pin),
    .secure_pin(secure_pin), .stored_key(stored_key),
    .pflash_read_req(pflash_read_req),
    .pflash_read_grant(pflash_read_grant),
    .pflash_read_margin(pflash_read_margin), .secured(secured),
    .protection_override(protection_override));

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic start_cmd(input logic [7:0] c, input logic [15:0] p);
    wr_reg(REG_CMD, {8'h0, c});
    wr_reg(REG_PARAM, p);
    wr_reg(REG_STATUS, 16'h0080);
  endtask : start_cmd

  // Polls the complete flag; blank bit only judged where masked in
  task automatic finish_cmd(input logic [15:0] m, input logic [15:0] e);
    logic [15:0] s;
    int          i;
    s = 16'h0;
    for (i = 0; i < 400 && s[ST_COMPLETE] !== 1'b1; i++) begin
      rd_reg(REG_STATUS, s);
    end
    check(s & m, e);
    if (s[ST_ERROR] === 1'b1) begin
      wr_reg(REG_STATUS, 16'h0020);
    end
  endtask : finish_cmd

  task automatic run_cmd(input logic [7:0] c, input logic [15:0] p,
                         input logic [15:0] m, input logic [15:0] e);
    start_cmd(c, p);
    finish_cmd(m, e);
  endtask : run_cmd

  task automatic probe(input logic g, input logic mg);
    pflash_read_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({14'h0, pflash_read_grant, pflash_read_margin}, {14'h0, g, mg});
    @(posedge clk);
    pflash_read_req <= 1'b0;
  endtask : probe

  task automatic do_reset(input logic special);
    resetn           <= 1'b0;
    special_mode_pin <= special;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(40000 * 100);
    n_errors++;
    report_and_stop();
  end

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    resetn = 1'b0; addr = 4'h0; wdata = 16'h0; wr = 1'b0; rd = 1'b0;
    special_mode_pin = 1'b0; secure_pin = 1'b1; stored_key = KEY;
    pflash_read_req = 1'b0;
    do_reset(1'b0);
    rd_reg(REG_STATUS, v);
    check(v & MA, OK);
    check({14'h0, secured, protection_override}, 16'h0002);
    rd_reg(4'hf, v);
    check(v, 16'h0);
    foreach (bad[i]) run_cmd(bad[i], 16'h0, ME, ERR);
    run_cmd(CMD_FIELD_MARG, 16'h0001, ME, ERR);
    run_cmd(CMD_PROG_EE, 16'h8005, ME, ERR);
    run_cmd(CMD_PROG_EE, 16'h8000, ME, ERR);
    wr_reg(REG_PROT, 16'h0007);
    run_cmd(CMD_ERASE_BLK, 16'h8000, ME, ERR);
    run_cmd(CMD_EV_BLOCK, 16'h0000, MA, BL);
    start_cmd(CMD_ERASE_BLK, 16'h0000);
    probe(1'b0, 1'b0);
    finish_cmd(ME, OK);
    run_cmd(CMD_EV_BLOCK, 16'h0000, MA, OK);
    start_cmd(CMD_PROG_EE, 16'h8004);
    probe(1'b1, 1'b0);
    finish_cmd(ME, OK);
    run_cmd(CMD_EV_EE_SECT, 16'h8004, MA, BL);
    run_cmd(CMD_EV_BLOCK, 16'h8000, MA, BL);
    run_cmd(CMD_EV_ALL, 16'h0, MA, BL);
    start_cmd(CMD_ERASE_EE, 16'h8000);
    probe(1'b1, 1'b0);
    finish_cmd(ME, OK);
    run_cmd(CMD_EV_BLOCK, 16'h8000, MA, OK);
    run_cmd(CMD_PROG_EE, 16'h8001, ME, OK);
    wr_reg(REG_PROT, 16'h0008);
    start_cmd(CMD_ERASE_BLK, 16'h8000);
    probe(1'b0, 1'b0);
    finish_cmd(ME, OK);
    run_cmd(CMD_EV_BLOCK, 16'h8000, MA, OK);
    run_cmd(CMD_USER_MARG, 16'h0001, ME, OK);
    probe(1'b0, 1'b1);
    run_cmd(CMD_USER_MARG, 16'h0000, ME, OK);
    probe(1'b1, 1'b0);
    run_cmd(CMD_USER_MARG, 16'h8002, ME, OK);
    rd_reg(REG_MARGIN, v);
    check(v, 16'h0008);
    probe(1'b1, 1'b0);
    run_cmd(CMD_USER_MARG, 16'h8000, ME, OK);
    wr_reg(REG_KEY, ~KEY);
    run_cmd(CMD_BACKDOOR, 16'h0, ME, ERR);
    run_cmd(CMD_PROT_OVR, 16'h0, ME, ERR);
    check({14'h0, secured, protection_override}, 16'h0002);
    wr_reg(REG_KEY, KEY);
    run_cmd(CMD_PROT_OVR, 16'h0, ME, OK);
    check({15'h0, protection_override}, 16'h0001);
    run_cmd(CMD_BACKDOOR, 16'h0, ME, OK);
    check({15'h0, secured}, 16'h0000);
    do_reset(1'b1);
    check({14'h0, secured, protection_override}, 16'h0002);
    run_cmd(CMD_PROG_EE, 16'h8001, ME, OK);
    wr_reg(REG_PROT, 16'h000f);
    run_cmd(CMD_UNSECURE, 16'h0, ME, OK);
    check({15'h0, secured}, 16'h0000);
    run_cmd(CMD_EV_ALL, 16'h0, MA, OK);
    run_cmd(CMD_PROG_EE, 16'h8002, ME, OK);
    wr_reg(REG_PROT, 16'h0000);
    run_cmd(CMD_ERASE_ALL, 16'h0, ME, ERR);
    wr_reg(REG_PROT, 16'h0007);
    run_cmd(CMD_ERASE_ALL, 16'h0, ME, ERR);
    wr_reg(REG_PROT, 16'h000f);
    start_cmd(CMD_ERASE_ALL, 16'h0);
    probe(1'b0, 1'b0);
    finish_cmd(ME, OK);
    run_cmd(CMD_EV_ALL, 16'h0, MA, OK);
    run_cmd(CMD_FIELD_MARG, 16'h0001, ME, OK);
    probe(1'b0, 1'b1);
    run_cmd(CMD_FIELD_MARG, 16'h0000, ME, OK);
    // Long idle lets the launch counter in the checker saturate
    repeat (1100) @(posedge clk);
    probe(1'b1, 1'b0);
    report_and_stop();
  end
endmodule : tb_flash_eeprom_command_set
`default_nettype wire
